// >>> core/qtm_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "qtm_regs.svh"

module qtm_top
  import qtm_pkg::*;
#(
  parameter int unsigned WARMUP_CYCLES = `QTM_WARMUP_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Prescaler source enables, pclk domain
  input  wire logic        geared_high_clock,
  input  wire logic        low_clock_tick,
  input  wire logic        high_div16_tick,
  // External count pins for timers 0 and 2
  input  wire logic [1:0]  ext_count_in,
  // Timer outputs and interrupt pulses
  output logic             timer_out_a,
  output logic             timer_out_b,
  output logic             timer0_irq,
  output logic             timer1_irq,
  output logic             timer2_irq,
  output logic             timer3_irq
);

  localparam logic [15:0] WARM_LOAD = 16'(WARMUP_CYCLES);

  // Address hit on an aligned word
  function automatic logic hit_idx(logic [11:0] a, logic [9:0] idx);
    return (a[11:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // Prescaler tap fires on the tick that brings its low bits to all ones
  function automatic logic tap(logic [8:0] pre, logic [8:0] mask);
    return &(pre | ~mask);
  endfunction

  // Comparator for the next count
  function automatic logic cmp_hit(logic [7:0] cnt, logic [7:0] cmp);
    return (cmp == 8'h00) ? (cnt == 8'hff) : (8'(cnt + 8'h01) == cmp);
  endfunction

  // Timer state
  logic [7:0]     cnt_q [4];
  logic [7:0]     cnt_d [4];
  logic [7:0]     cmp_q [4];
  logic [7:0]     cmp_d [4];
  logic [7:0]     buf_q [2];
  logic [7:0]     buf_d [2];
  logic [1:0]     tff_q, tff_d;
  logic [1:0]     susp_q, susp_d;
  logic [3:0]     irq_q, irq_d;
  // Register state
  logic [3:0]     run_q, run_d;
  logic           prun_q, prun_d;
  qtm_mode_type   mode_q [2];
  qtm_mode_type   mode_d [2];
  qtm_toggle_type tgl_q [2];
  qtm_toggle_type tgl_d [2];
  logic [1:0]     dben_q, dben_d;
  logic [7:0]     sys_q, sys_d;
  logic [15:0]    warm_q, warm_d;
  // Prescaler and pin state
  logic [1:0]     div_q, div_d;
  logic [8:0]     pre_q, pre_d;
  logic           ptick_q, ptick_d;
  logic [1:0]     ext_s1_q, ext_s2_q, ext_prev_q;
  // Bus state
  logic [31:0]    rdata_q, rdata_d;
  logic           ready_q, ready_d;
  logic           err_q, err_d;

  logic           wr;
  logic [7:0]     wd;
  logic           mapped;
  logic [1:0]     ext_rise;
  logic           t1, t4, t16, t256;

  assign wr       = psel & penable & pwrite & ready_q;
  assign wd       = pwdata[7:0];
  assign ext_rise = ext_s2_q & ~ext_prev_q;
  // Timer clocks are one-cycle enables off the prescaler
  assign t1   = ptick_q & tap(pre_q, `QTM_TAP_T1);
  assign t4   = ptick_q & tap(pre_q, `QTM_TAP_T4);
  assign t16  = ptick_q & tap(pre_q, `QTM_TAP_T16);
  assign t256 = ptick_q & tap(pre_q, `QTM_TAP_T256);

  // Prescaler, divide by four then nine-bit chain
  always_comb begin
    logic src;
    src     = 1'b0;
    div_d   = div_q;
    pre_d   = pre_q;
    ptick_d = 1'b0;
    case (sys_q[1:0])
      `QTM_SRC_GEARED: src = geared_high_clock;
      `QTM_SRC_LOW:    src = low_clock_tick;
      `QTM_SRC_DIV16:  src = high_div16_tick;
      default:         src = 1'b0;
    endcase
    if (!prun_q) begin
      div_d = 2'b00;
      pre_d = 9'h000;
    end else if (src) begin
      div_d = 2'(div_q + 2'b01);
      if (div_q == 2'b11) begin
        ptick_d = 1'b1;
        pre_d   = 9'(pre_q + 9'h001);
      end
    end
  end

  // Counters, comparators and output flip-flops
  always_comb begin
    logic [7:0]  nl;
    logic [7:0]  nh;
    logic [7:0]  pmask;
    logic        lt, ht, lm, hm, tog;
    logic [15:0] c16, k16;
    int          lo, hi;
    nl = 8'h00; nh = 8'h00; pmask = 8'h00;
    lt = 1'b0; ht = 1'b0; lm = 1'b0; hm = 1'b0; tog = 1'b0;
    c16 = 16'h0000; k16 = 16'h0000; lo = 0; hi = 1;
    cnt_d  = cnt_q;
    cmp_d  = cmp_q;
    buf_d  = buf_q;
    tff_d  = tff_q;
    susp_d = susp_q;
    irq_d  = 4'h0;
    for (int p = 0; p < 2; p++) begin
      lo  = 2 * p;
      hi  = 2 * p + 1;
      tog = 1'b0;
      nl  = 8'(cnt_q[lo] + 8'h01);
      nh  = 8'(cnt_q[hi] + 8'h01);
      case (mode_q[p].lo_sel)
        2'b00:   lt = ext_rise[p];
        2'b01:   lt = t1;
        2'b10:   lt = t4;
        default: lt = t16;
      endcase
      lt = lt & run_q[lo];
      lm = lt & cmp_hit(cnt_q[lo], cmp_q[lo]);
      case (mode_q[p].pwm)
        2'b01:   pmask = `QTM_PWM_MASK6;
        2'b10:   pmask = `QTM_PWM_MASK7;
        default: pmask = `QTM_PWM_MASK8;
      endcase
      // Lower timer
      case (mode_q[p].mode)
        `QTM_MODE_16BIT: begin
          c16 = {cnt_q[hi], cnt_q[lo]};
          k16 = {cmp_q[hi], cmp_q[lo]};
          if (lt) begin
            cnt_d[lo] = nl;
            if ((k16 == 16'h0000) ? (c16 == 16'hffff)
                : (16'(c16 + 16'h0001) == k16)) begin
              if (!susp_q[p]) begin
                cnt_d[lo] = 8'h00;
                cnt_d[hi] = 8'h00;
                irq_d[hi] = 1'b1;
                tog       = 1'b1;
              end else if (cnt_q[lo] == 8'hff) begin
                cnt_d[hi] = nh;
              end
            end else if (cnt_q[lo] == 8'hff && run_q[hi]) begin
              cnt_d[hi] = nh;
            end
          end
        end
        `QTM_MODE_PPG: begin
          cnt_d[hi] = 8'h00;
          if (lt) begin
            if (nl == cmp_q[hi]) begin
              cnt_d[lo] = 8'h00;
              irq_d[lo] = 1'b1;
              tog       = 1'b1;
              if (dben_q[p]) begin
                cmp_d[lo] = buf_q[p];
              end
            end else begin
              cnt_d[lo] = nl;
              tog       = (nl == cmp_q[lo]);
            end
          end
        end
        `QTM_MODE_PWM: begin
          if (lt) begin
            if (cnt_q[lo] == pmask) begin
              cnt_d[lo] = 8'h00;
              irq_d[lo] = 1'b1;
              tog       = 1'b1;
              if (dben_q[p]) begin
                cmp_d[lo] = buf_q[p];
              end
            end else begin
              cnt_d[lo] = nl;
              tog       = (nl == cmp_q[lo]);
            end
          end
        end
        default: begin
          if (lm) begin
            cnt_d[lo] = 8'h00;
            irq_d[lo] = 1'b1;
            tog       = !tgl_q[p].src_upper;
          end else if (lt) begin
            cnt_d[lo] = nl;
          end
        end
      endcase
      // Upper timer as an 8-bit timer
      if (mode_q[p].mode == `QTM_MODE_8BIT ||
          mode_q[p].mode == `QTM_MODE_PWM) begin
        case (mode_q[p].hi_sel)
          2'b00:   ht = lm && (mode_q[p].mode == `QTM_MODE_8BIT);
          2'b01:   ht = t1;
          2'b10:   ht = t16;
          default: ht = t256;
        endcase
        ht = ht & run_q[hi];
        hm = ht & cmp_hit(cnt_q[hi], cmp_q[hi]);
        if (hm) begin
          cnt_d[hi] = 8'h00;
          irq_d[hi] = 1'b1;
          if (mode_q[p].mode == `QTM_MODE_8BIT && tgl_q[p].src_upper) begin
            tog = 1'b1;
          end
        end else if (ht) begin
          cnt_d[hi] = nh;
        end
      end
      if (!run_q[lo]) begin
        cnt_d[lo] = 8'h00;
      end
      if (!run_q[hi]) begin
        cnt_d[hi] = 8'h00;
      end
      if (tog && tgl_q[p].invert_en) begin
        tff_d[p] = ~tff_q[p];
      end
    end
    // Lower compare writes (CMP0, CMP2) share one address with the buffer
    if (wr) begin
      for (int p = 0; p < 2; p++) begin
        if (hit_idx(paddr, (p == 0) ? `QTM_IDX_CMP0 : `QTM_IDX_CMP2)) begin
          buf_d[p] = wd;
          if (!dben_q[p]) begin
            cmp_d[2 * p] = wd;
          end
          if (mode_q[p].mode == `QTM_MODE_16BIT) begin
            susp_d[p] = 1'b1;
          end
        end
        if (hit_idx(paddr, (p == 0) ? `QTM_IDX_CMP1 : `QTM_IDX_CMP3)) begin
          cmp_d[2 * p + 1] = wd;
          susp_d[p]        = 1'b0;
        end
      end
      // Software force of the output flip-flops
      if (hit_idx(paddr, `QTM_IDX_TOGGLE)) begin
        for (int p = 0; p < 2; p++) begin
          case (wd[4 * p + 3 -: 2])
            `QTM_FORCE_INVERT: tff_d[p] = ~tff_q[p];
            `QTM_FORCE_SET:    tff_d[p] = 1'b1;
            `QTM_FORCE_CLEAR:  tff_d[p] = 1'b0;
            default:           tff_d[p] = tff_d[p];
          endcase
        end
      end
    end
  end

  // Control registers and warm-up timer
  always_comb begin
    run_d  = run_q;
    prun_d = prun_q;
    mode_d = mode_q;
    tgl_d  = tgl_q;
    dben_d = dben_q;
    sys_d  = sys_q;
    warm_d = (warm_q != 16'h0000) ? 16'(warm_q - 16'h0001) : warm_q;
    if (wr) begin
      if (hit_idx(paddr, `QTM_IDX_RUN)) begin
        prun_d = wd[`QTM_RUN_PRESCALER];
        run_d  = wd[3:0];
      end
      if (hit_idx(paddr, `QTM_IDX_MODE_A)) begin
        mode_d[0] = wd;
      end
      if (hit_idx(paddr, `QTM_IDX_MODE_B)) begin
        mode_d[1] = wd;
      end
      if (hit_idx(paddr, `QTM_IDX_TOGGLE)) begin
        tgl_d[0] = wd[1:0];
        tgl_d[1] = wd[5:4];
      end
      if (hit_idx(paddr, `QTM_IDX_DBUF)) begin
        dben_d = wd[1:0];
      end
      if (hit_idx(paddr, `QTM_IDX_SYSCLK)) begin
        sys_d = wd;
        sys_d[`QTM_SYS_WARMUP] = 1'b0;
        if (wd[`QTM_SYS_WARMUP]) begin
          warm_d = WARM_LOAD;
        end
      end
    end
  end

  // APB: answer in the access phase with one wait-free cycle
  always_comb begin
    mapped  = 1'b1;
    rdata_d = 32'h0000_0000;
    ready_d = psel & ~penable;
    err_d   = 1'b0;
    if (hit_idx(paddr, `QTM_IDX_RUN)) begin
      rdata_d[7:0] = {prun_q, 3'b000, run_q} | `QTM_RUN_BIT6;
    end else if (hit_idx(paddr, `QTM_IDX_MODE_A)) begin
      rdata_d[7:0] = mode_q[0];
    end else if (hit_idx(paddr, `QTM_IDX_MODE_B)) begin
      rdata_d[7:0] = mode_q[1];
    end else if (hit_idx(paddr, `QTM_IDX_TOGGLE)) begin
      rdata_d[7:0] = {2'b11, tgl_q[1], 2'b11, tgl_q[0]};
    end else if (hit_idx(paddr, `QTM_IDX_DBUF)) begin
      rdata_d[7:0] = {6'b00_0000, dben_q};
    end else if (hit_idx(paddr, `QTM_IDX_SYSCLK)) begin
      rdata_d[7:0] = sys_q;
      rdata_d[`QTM_SYS_WARMUP] = (warm_q != 16'h0000);
    end else if (hit_idx(paddr, `QTM_IDX_CMP0) ||
                 hit_idx(paddr, `QTM_IDX_CMP1) ||
                 hit_idx(paddr, `QTM_IDX_CMP2) ||
                 hit_idx(paddr, `QTM_IDX_CMP3)) begin
      rdata_d = 32'h0000_0000;
    end else begin
      mapped = 1'b0;
    end
    err_d = psel & ~penable & ~mapped;
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= '{default: 8'h00};
      cmp_q      <= '{default: 8'h00};
      buf_q      <= '{default: 8'h00};
      tff_q      <= 2'b00;
      susp_q     <= 2'b00;
      irq_q      <= 4'h0;
      run_q      <= 4'h0;
      prun_q     <= 1'b0;
      mode_q     <= '{default: 8'h00};
      tgl_q      <= '{default: 2'b00};
      dben_q     <= 2'b00;
      sys_q      <= `QTM_SYSCLK_RESET;
      warm_q     <= 16'h0000;
      div_q      <= 2'b00;
      pre_q      <= 9'h000;
      ptick_q    <= 1'b0;
      ext_s1_q   <= 2'b00;
      ext_s2_q   <= 2'b00;
      ext_prev_q <= 2'b00;
      rdata_q    <= 32'h0000_0000;
      ready_q    <= 1'b0;
      err_q      <= 1'b0;
    end else if (ce) begin
      cnt_q      <= cnt_d;
      cmp_q      <= cmp_d;
      buf_q      <= buf_d;
      tff_q      <= tff_d;
      susp_q     <= susp_d;
      irq_q      <= irq_d;
      run_q      <= run_d;
      prun_q     <= prun_d;
      mode_q     <= mode_d;
      tgl_q      <= tgl_d;
      dben_q     <= dben_d;
      sys_q      <= sys_d;
      warm_q     <= warm_d;
      div_q      <= div_d;
      pre_q      <= pre_d;
      ptick_q    <= ptick_d;
      ext_s1_q   <= ext_count_in;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      rdata_q    <= rdata_d;
      ready_q    <= ready_d;
      err_q      <= err_d;
    end
  end

  // Outputs straight from flops
  assign prdata      = rdata_q;
  assign pready      = ready_q;
  assign pslverr     = err_q;
  assign timer_out_a = tff_q[0];
  assign timer_out_b = tff_q[1];
  assign timer0_irq  = irq_q[0];
  assign timer1_irq  = irq_q[1];
  assign timer2_irq  = irq_q[2];
  assign timer3_irq  = irq_q[3];

endmodule // qtm_top
`default_nettype wire

// >>> core/qtm_regs.svh
`ifndef QTM_REGS_SVH
`define QTM_REGS_SVH

// Register indices; the byte address is four times the index
`define QTM_IDX_RUN       10'h020
`define QTM_IDX_CMP0      10'h022
`define QTM_IDX_CMP1      10'h023
`define QTM_IDX_MODE_A    10'h024
`define QTM_IDX_MODE_B    10'h025
`define QTM_IDX_CMP2      10'h026
`define QTM_IDX_CMP3      10'h027
`define QTM_IDX_TOGGLE    10'h028
`define QTM_IDX_DBUF      10'h029
`define QTM_IDX_SYSCLK    10'h06e

// Reset values
`define QTM_SYSCLK_RESET  8'ha0
`define QTM_RUN_BIT6      8'h40

// Run control field positions
`define QTM_RUN_PRESCALER 7

// System clock control field positions
`define QTM_SYS_WARMUP    2

// Pair mode codes
`define QTM_MODE_8BIT     2'b00
`define QTM_MODE_16BIT    2'b01
`define QTM_MODE_PPG      2'b10
`define QTM_MODE_PWM      2'b11

// Output flip-flop force codes
`define QTM_FORCE_INVERT  2'b00
`define QTM_FORCE_SET     2'b01
`define QTM_FORCE_CLEAR   2'b10

// Prescaler source codes
`define QTM_SRC_GEARED    2'b00
`define QTM_SRC_LOW       2'b01
`define QTM_SRC_DIV16     2'b10

// PWM period masks
`define QTM_PWM_MASK6     8'h3f
`define QTM_PWM_MASK7     8'h7f
`define QTM_PWM_MASK8     8'hff

// Prescaler tap masks for the four timer clocks
`define QTM_TAP_T1        9'h001
`define QTM_TAP_T4        9'h007
`define QTM_TAP_T16       9'h01f
`define QTM_TAP_T256      9'h1ff

// Warm-up length in pclk cycles
`define QTM_WARMUP_CYCLES 16

`endif

// >>> core/qtm_pkg.sv
`default_nettype none
package qtm_pkg;

  // Pair mode register layout
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] pwm;
    logic [1:0] hi_sel;
    logic [1:0] lo_sel;
  } qtm_mode_type;

  // Per pair output flip-flop control
  typedef struct packed {
    logic invert_en;
    logic src_upper;
  } qtm_toggle_type;

endpackage
`default_nettype wire

// >>> core/qtm_top_unused_guard.sv
`timescale 1ns/10ps

// >>> tb/qtm_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "qtm_regs.svh"

module qtm_top_asserts (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Timer outputs
  input wire logic        timer_out_a,
  input wire logic        timer_out_b,
  input wire logic        timer0_irq,
  input wire logic        timer2_irq
);
  logic rd_acc;
  logic wr_tog;

  // Completed bus accesses
  assign rd_acc = psel && penable && pready && !pwrite;
  assign wr_tog = psel && penable && pready && pwrite && ce
                  && paddr[11:2] == `QTM_IDX_TOGGLE;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready && ce |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_run_bit6: assert property (
    rd_acc && paddr[11:2] == `QTM_IDX_RUN |-> prdata[6] && prdata[31:8] == 0)
    else $error("run register bit 6 low");
  a_force_read_ones: assert property (
    rd_acc && paddr[11:2] == `QTM_IDX_TOGGLE
    |-> prdata[7:6] == 2'b11 && prdata[3:2] == 2'b11)
    else $error("force field not ones");
  a_cmp_write_only: assert property (
    rd_acc && paddr[11:2] inside {`QTM_IDX_CMP0, `QTM_IDX_CMP1,
    `QTM_IDX_CMP2, `QTM_IDX_CMP3} |-> prdata == 0)
    else $error("compare register readable");
  a_force_set_a: assert property (
    wr_tog && pwdata[3:2] == 2'b01 |=> timer_out_a)
    else $error("force set failed");
  a_force_clear_b: assert property (
    wr_tog && pwdata[7:6] == 2'b10 |=> !timer_out_b)
    else $error("force clear failed");
  a_force_invert_a: assert property (
    wr_tog && pwdata[3:2] == 2'b00 |=> timer_out_a != $past(timer_out_a))
    else $error("software invert failed");
  a_irq_single_pulse: assert property (
    (timer0_irq |=> !timer0_irq) and (timer2_irq |=> !timer2_irq))
    else $error("interrupt pulse too long");
endmodule // qtm_top_asserts

bind qtm_top qtm_top_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_out_a(timer_out_a), .timer_out_b(timer_out_b),
  .timer0_irq(timer0_irq), .timer2_irq(timer2_irq)
);
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "qtm_regs.svh"

module tb;
  localparam int          WARM  = 8;
  localparam int          LIMIT = 20000;
  localparam logic [11:0] A_RUN = {`QTM_IDX_RUN, 2'b00};
  localparam logic [11:0] A_C0  = {`QTM_IDX_CMP0, 2'b00};
  localparam logic [11:0] A_C1  = {`QTM_IDX_CMP1, 2'b00};
  localparam logic [11:0] A_MOD = {`QTM_IDX_MODE_A, 2'b00};
  localparam logic [11:0] A_TOG = {`QTM_IDX_TOGGLE, 2'b00};
  localparam logic [11:0] A_BUF = {`QTM_IDX_DBUF, 2'b00};
  localparam logic [11:0] A_SYS = {`QTM_IDX_SYSCLK, 2'b00};
  localparam logic [11:0] A_MODB = {`QTM_IDX_MODE_B, 2'b00};
  localparam logic [11:0] A_C2  = {`QTM_IDX_CMP2, 2'b00};
  localparam logic [11:0] A_C3  = {`QTM_IDX_CMP3, 2'b00};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        err, out_a, out_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  ext;
  logic [2:0]  srcs;
  wire  [3:0]  irq;
  int          bad_count, samples_checked, cyc;
  int          n_irq [4];

  qtm_top #(.WARMUP_CYCLES(WARM)) dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .geared_high_clock(srcs[0]), .low_clock_tick(srcs[1]),
    .high_div16_tick(srcs[2]), .ext_count_in(ext),
    .timer_out_a(out_a), .timer_out_b(out_b), .timer0_irq(irq[0]),
    .timer1_irq(irq[1]), .timer2_irq(irq[2]), .timer3_irq(irq[3])
  );

  // Clock
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // Hang guard and interrupt pulse counting
  always @(posedge pclk) begin
    cyc++;
    for (int i = 0; i < 4; i++) if (irq[i] === 1'b1) n_irq[i]++;
    if (cyc == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd_is(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // Rising edges on the chosen count pins
  task automatic tick_on(input logic [1:0] m, input int n);
    repeat (n) begin
      ext <= m;
      repeat (4) @(posedge pclk);
      ext <= 2'b00;
      repeat (4) @(posedge pclk);
    end
  endtask

  // Rising edges on the timer 0 count pin
  task automatic tick(input int n);
    tick_on(2'b01, n);
  endtask

  task automatic irq_is(input int i, input int n);
    repeat (8) @(posedge pclk);
    check(n_irq[i], n);
  endtask

  task automatic clr();
    for (int i = 0; i < 4; i++) n_irq[i] = 0;
  endtask

  task automatic s_reset();
    rd_is(A_SYS, 32'h0000_00a0);
    rd_is(A_RUN, 32'h0000_0040);
    rd_is(A_BUF, 32'h0000_0000);
    wr(A_C0, 8'h55);
    rd_is(A_C0, 32'h0000_0000);
    rd_is(12'h004, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
  endtask

  task automatic s_warm();
    wr(A_SYS, 8'ha4);
    rd_is(A_SYS, 32'h0000_00a4);
    repeat (2 * WARM) @(posedge pclk);
    rd_is(A_SYS, 32'h0000_00a0);
  endtask

  task automatic s_force();
    wr(A_TOG, 8'h44);
    check({30'h0, out_b, out_a}, 32'h0000_0003);
    wr(A_TOG, 8'h88);
    check({30'h0, out_b, out_a}, 32'h0000_0000);
    wr(A_TOG, 8'h00);
    check({30'h0, out_b, out_a}, 32'h0000_0003);
    rd_is(A_TOG, 32'h0000_00cc);
  endtask

  task automatic s_timer();
    wr(A_MOD, 8'h00);
    wr(A_C0, 8'h03);
    wr(A_C1, 8'h02);
    wr(A_TOG, 8'h08);
    wr(A_TOG, 8'h0e);
    clr();
    wr(A_RUN, 8'h03);
    tick(3);
    irq_is(0, 1);
    check({31'h0, out_a}, 32'h0000_0001);
    tick(3);
    irq_is(0, 2);
    irq_is(1, 1);
    check({31'h0, out_a}, 32'h0000_0000);
  endtask

  task automatic s_stop();
    clr();
    tick(2);
    wr(A_RUN, 8'h00);
    wr(A_RUN, 8'h01);
    rd_is(A_RUN, 32'h0000_0041);
    tick(2);
    irq_is(0, 0);
    tick(1);
    irq_is(0, 1);
  endtask

  task automatic s_buffer();
    wr(A_RUN, 8'h00);
    wr(A_BUF, 8'h01);
    wr(A_C0, 8'h05);
    wr(A_RUN, 8'h01);
    clr();
    tick(3);
    irq_is(0, 1);
    tick(3);
    irq_is(0, 2);
  endtask

  task automatic s_zero();
    wr(A_RUN, 8'h00);
    wr(A_BUF, 8'h00);
    wr(A_C0, 8'h00);
    wr(A_RUN, 8'h01);
    clr();
    tick(255);
    irq_is(0, 0);
    tick(1);
    irq_is(0, 1);
  endtask

  task automatic s_wide();
    wr(A_RUN, 8'h00);
    wr(A_MOD, 8'h40);
    wr(A_C1, 8'h00);
    wr(A_C0, 8'h01);
    wr(A_TOG, 8'hca);
    clr();
    wr(A_RUN, 8'h03);
    tick(2);
    irq_is(1, 0);
    wr(A_RUN, 8'h00);
    wr(A_C1, 8'h01);
    wr(A_RUN, 8'h03);
    tick(256);
    irq_is(1, 0);
    tick(1);
    irq_is(1, 1);
    check({31'h0, out_a}, 32'h0000_0001);
    check(n_irq[0], 32'h0000_0000);
  endtask

  task automatic s_ppg();
    wr(A_RUN, 8'h00);
    wr(A_MODB, 8'h80);
    wr(A_C2, 8'h02);
    wr(A_C3, 8'h04);
    wr(A_BUF, 8'h02);
    wr(A_C2, 8'h01);
    wr(A_TOG, 8'hae);
    clr();
    wr(A_RUN, 8'h0c);
    tick_on(2'b10, 1);
    check({31'h0, out_b}, 32'h0000_0000);
    tick_on(2'b10, 1);
    check({31'h0, out_b}, 32'h0000_0001);
    tick_on(2'b10, 2);
    irq_is(2, 1);
    check({31'h0, out_b}, 32'h0000_0000);
    tick_on(2'b10, 1);
    check({31'h0, out_b}, 32'h0000_0001);
    check(n_irq[3], 32'h0000_0000);
  endtask

  task automatic s_pwm();
    wr(A_RUN, 8'h00);
    wr(A_MOD, 8'hd0);
    wr(A_BUF, 8'h00);
    wr(A_C0, 8'h04);
    wr(A_BUF, 8'h01);
    wr(A_C0, 8'h08);
    wr(A_TOG, 8'hca);
    clr();
    wr(A_RUN, 8'h01);
    tick(4);
    check({31'h0, out_a}, 32'h0000_0001);
    tick(60);
    irq_is(0, 1);
    check({31'h0, out_a}, 32'h0000_0000);
    tick(4);
    check({31'h0, out_a}, 32'h0000_0000);
    tick(4);
    check({31'h0, out_a}, 32'h0000_0001);
  endtask

  // Sixty-four source ticks give sixteen divided ticks, eight T1 ticks
  task automatic pre_run(input logic [7:0] s, input logic [2:0] m,
                         input int n);
    wr(A_RUN, 8'h00);
    wr(A_SYS, s);
    clr();
    wr(A_RUN, 8'h81);
    srcs <= m;
    repeat (64) @(posedge pclk);
    srcs <= 3'b000;
    irq_is(0, n);
  endtask

  task automatic s_pre();
    wr(A_RUN, 8'h00);
    wr(A_MOD, 8'h01);
    wr(A_BUF, 8'h00);
    wr(A_C0, 8'h01);
    pre_run(8'ha0, 3'b001, 8);
    pre_run(8'ha1, 3'b101, 0);
    pre_run(8'ha2, 3'b100, 8);
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    ext     = 2'b00;
    srcs    = 3'b000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset();
    s_warm();
    s_force();
    s_timer();
    s_stop();
    s_buffer();
    s_zero();
    s_wide();
    s_ppg();
    s_pwm();
    s_pre();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
